// [verilog/gpl_defines.vh]
// Constants for the three-port general-purpose I/O block.
// Assumes an 8-bit internal CPU bus with 16-bit byte addresses.
// Overview of operation
// - Direction bit 0 turns the pin's output buffer on; 1 makes it input.
// - Output mode drives latch value on the pin; input mode reads the pin level.
// - Reset-shared input bit of port 3 is read-only; the other port 3 bit is read-write.
// - Analog bit 0 selects digital or alternate use; 1 selects converter input.
// - Reset clears all analog-mode bits so every pin starts digital.
// - Analog pin loses port function; software keeps its pull-up bit at 0.
// - Pull-up bit 1 connects the on-chip pull-up; 0 leaves it off.
// - Reset clears every pull-up selection register.
// - A bit instruction reads, modifies and rewrites the whole port byte.
// - Output-mode write updates the latch, drives the pin, holds until rewritten.
// - Input-mode write updates and keeps the latch; pin stays undriven.
// - Read returns pin level for inputs, latch for outputs; latch unchanged.
// - Output-mode read-modify-write works on latch, stores and drives the result.
// - Input-mode read-modify-write works on pin level, stores in latch only.
// - Reset clears the output latches of all ports.
`ifndef GPL_DEFINES_VH
`define GPL_DEFINES_VH

// Register byte addresses.
`define GPL_ADDR_PORT2_DATA 16'hff02
`define GPL_ADDR_PORT3_DATA 16'hff03
`define GPL_ADDR_PORT4_DATA 16'hff04
`define GPL_ADDR_PORT2_DIR 16'hff22
`define GPL_ADDR_PORT3_DIR 16'hff23
`define GPL_ADDR_PORT4_DIR 16'hff24
`define GPL_ADDR_PORT2_PULLUP 16'hff32
`define GPL_ADDR_PORT3_PULLUP 16'hff33
`define GPL_ADDR_PORT4_PULLUP 16'hff34
`define GPL_ADDR_PORT2_ANALOG 16'hff84

// Implemented bit masks.
`define GPL_PORT2_MASK 8'h0f
`define GPL_PORT3_WR_MASK 8'h04
`define GPL_PORT3_RD_MASK 8'h14
`define GPL_PORT4_MASK 8'hff
`define GPL_ANALOG_MASK 8'h0f

// Field positions.
`define GPL_P3_IO_BIT 2
`define GPL_P3_RST_IN_BIT 4

// Reset values.
`define GPL_LATCH_RST 8'h00
`define GPL_PULLUP_RST 8'h00
`define GPL_ANALOG_RST 8'h00
`define GPL_DIR_RST 8'hff
`define GPL_RDATA_RST 8'h00

`endif

// [verilog/gpl_sync.v]
// Two-stage synchroniser for a vector of pin levels.
// Assumes the inputs are unrelated to clk; each bit is crossed on its own.
`timescale 1ns/1ps
`default_nettype none
module gpl_sync #(
   parameter W = 1
) (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Asynchronous levels in, synchronised levels out
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);
   reg [W-1:0] meta;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

// [verilog/gpl_port.v]
// One 8-bit port: output latch and direction-dependent readback.
// Assumes pin levels arrive already synchronised and direction bits are 1 on
// unimplemented positions, so those positions never select the latch.
`timescale 1ns/1ps
`default_nettype none
`include "gpl_defines.vh"
module gpl_port #(
   parameter [7:0] WR_MASK = 8'hff,
   parameter [7:0] RD_MASK = 8'hff
) (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Latch write
   input wire wr_en,
   input wire [7:0] wr_data,
   // Pin state
   input wire [7:0] dir,
   input wire [7:0] pin_lvl,
   // Results
   output reg [7:0] latch,
   output wire [7:0] rd_val
);
   // Input pins show their level, output pins their latch.
   assign rd_val = ((dir & pin_lvl) | (~dir & latch)) & RD_MASK;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         latch <= `GPL_LATCH_RST;
      end else if (wr_en) begin
         // The latch takes the write regardless of direction and holds it.
         latch <= wr_data & WR_MASK;
      end
   end
endmodule
`default_nettype wire

// [verilog/gpl_top.v]
// Port logic for the 4-bit, 2-bit and 8-bit ports with pull-up and analog select.
// Assumes a CPU on the same clock issuing single-cycle read, write and
// bit-manipulation strobes; pins and the reset-shared input are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "gpl_defines.vh"
module gpl_top (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // CPU internal bus
   input wire [15:0] cpu_addr,
   input wire [7:0] cpu_wdata,
   input wire cpu_wr,
   input wire cpu_rd,
   input wire cpu_bit_wr,
   input wire [2:0] cpu_bit_sel,
   input wire cpu_bit_val,
   output reg [7:0] cpu_rdata,
   output reg cpu_rvalid,
   // Port 2 pins
   input wire [3:0] p2_pin_in,
   output reg [3:0] p2_pin_out,
   output reg [3:0] p2_pin_oe,
   output reg [3:0] p2_pullup_en,
   // Port 3 pins
   input wire p3_pin_in,
   input wire reset_shared_input,
   output reg p3_pin_out,
   output reg p3_pin_oe,
   output reg p3_pullup_en,
   // Port 4 pins
   input wire [7:0] p4_pin_in,
   output reg [7:0] p4_pin_out,
   output reg [7:0] p4_pin_oe,
   output reg [7:0] p4_pullup_en,
   // Analog converter side
   output reg [3:0] analog_mode_bit,
   // Alternate-function peripherals
   input wire timer_h_output,
   input wire timer0_output,
   output reg timer0_capture_in_a,
   output reg timer0_capture_in_b,
   output reg ext_irq_in_0,
   output reg ext_irq_in_1
);
   // Control registers.
   reg [7:0] dir2;
   reg [7:0] dir3;
   reg [7:0] dir4;
   reg [7:0] pullup2;
   reg [7:0] pullup3;
   reg [7:0] pullup4;
   reg [7:0] analog_mode_select;

   // Synchronised pins.
   wire [13:0] pin_async;
   wire [13:0] pin_sync;
   wire [3:0] s_p2;
   wire s_p32;
   wire s_rst_in;
   wire [7:0] s_p4;

   // Pin levels as seen by port reads.
   wire [7:0] lvl2;
   wire [7:0] lvl3;
   wire [7:0] lvl4;

   // Latches and readback values.
   wire [7:0] latch2;
   wire [7:0] latch3;
   wire [7:0] latch4;
   wire [7:0] rd2;
   wire [7:0] rd3;
   wire [7:0] rd4;

   // Address decode.
   wire sel_p2;
   wire sel_p3;
   wire sel_p4;
   wire sel_d2;
   wire sel_d3;
   wire sel_d4;
   wire sel_u2;
   wire sel_u3;
   wire sel_u4;
   wire sel_am;

   // Per-register write enables; a bit instruction counts as a write.
   wire we_p2;
   wire we_p3;
   wire we_p4;
   wire we_d2;
   wire we_d3;
   wire we_d4;
   wire we_u2;
   wire we_u3;
   wire we_u4;
   wire we_am;

   // Port 2 direction as its port logic sees it.
   wire [7:0] dir2_eff;

   // Effective write after bit merge.
   reg [7:0] rd_mux;
   reg [7:0] bit_merged;
   wire wr_any;
   wire [7:0] wr_val;

   assign pin_async = {p4_pin_in, reset_shared_input, p3_pin_in, p2_pin_in};

   gpl_sync #(
      .W(14)
   ) u_sync (
      .clk(clk),
      .resetn(resetn),
      .async_in(pin_async),
      .sync_out(pin_sync)
   );

   assign s_p2 = pin_sync[3:0];
   assign s_p32 = pin_sync[4];
   assign s_rst_in = pin_sync[5];
   assign s_p4 = pin_sync[13:6];

   // An analog-mode pin has its digital input path cut, so it reads 0.
   assign lvl2 = {4'h0, s_p2 & ~analog_mode_select[3:0]};
   assign lvl3 = {3'b000, s_rst_in, 1'b0, s_p32, 2'b00};
   assign lvl4 = s_p4;

   assign sel_p2 = (cpu_addr == `GPL_ADDR_PORT2_DATA);
   assign sel_p3 = (cpu_addr == `GPL_ADDR_PORT3_DATA);
   assign sel_p4 = (cpu_addr == `GPL_ADDR_PORT4_DATA);
   assign sel_d2 = (cpu_addr == `GPL_ADDR_PORT2_DIR);
   assign sel_d3 = (cpu_addr == `GPL_ADDR_PORT3_DIR);
   assign sel_d4 = (cpu_addr == `GPL_ADDR_PORT4_DIR);
   assign sel_u2 = (cpu_addr == `GPL_ADDR_PORT2_PULLUP);
   assign sel_u3 = (cpu_addr == `GPL_ADDR_PORT3_PULLUP);
   assign sel_u4 = (cpu_addr == `GPL_ADDR_PORT4_PULLUP);
   assign sel_am = (cpu_addr == `GPL_ADDR_PORT2_ANALOG);

   // Addresses are distinct, so at most one register changes per cycle.
   assign we_p2 = wr_any & sel_p2;
   assign we_p3 = wr_any & sel_p3;
   assign we_p4 = wr_any & sel_p4;
   assign we_d2 = wr_any & sel_d2;
   assign we_d3 = wr_any & sel_d3;
   assign we_d4 = wr_any & sel_d4;
   assign we_u2 = wr_any & sel_u2;
   assign we_u3 = wr_any & sel_u3;
   assign we_u4 = wr_any & sel_u4;
   assign we_am = wr_any & sel_am;

   // An analog pin counts as an input, so a port read shows its cut input
   // path as 0 instead of its latch, and a bit instruction does the same.
   assign dir2_eff = dir2 | {4'h0, analog_mode_select[3:0]};

   // Read value of the addressed register; unmapped addresses read 0.
   always @* begin
      rd_mux = 8'h00;
      if (sel_p2) begin
         rd_mux = rd2;
      end else if (sel_p3) begin
         rd_mux = rd3;
      end else if (sel_p4) begin
         rd_mux = rd4;
      end else if (sel_d2) begin
         rd_mux = dir2;
      end else if (sel_d3) begin
         rd_mux = dir3;
      end else if (sel_d4) begin
         rd_mux = dir4;
      end else if (sel_u2) begin
         rd_mux = pullup2;
      end else if (sel_u3) begin
         rd_mux = pullup3;
      end else if (sel_u4) begin
         rd_mux = pullup4;
      end else if (sel_am) begin
         rd_mux = analog_mode_select;
      end
   end

   // A bit instruction starts from the whole byte as read, so input pins feed
   // their current level back into their latch bits.
   // In a port that mixes inputs and outputs those latch bits are thus not
   // preserved, a limitation that software has to live with.
   always @* begin
      bit_merged = rd_mux;
      bit_merged[cpu_bit_sel] = cpu_bit_val;
   end

   // A bit instruction takes precedence over a byte write in the same cycle.
   assign wr_any = cpu_wr | cpu_bit_wr;
   assign wr_val = cpu_bit_wr ? bit_merged : cpu_wdata;

   gpl_port #(
      .WR_MASK(`GPL_PORT2_MASK),
      .RD_MASK(`GPL_PORT2_MASK)
   ) u_port2 (
      .clk(clk),
      .resetn(resetn),
      .wr_en(we_p2),
      .wr_data(wr_val),
      .dir(dir2_eff),
      .pin_lvl(lvl2),
      .latch(latch2),
      .rd_val(rd2)
   );

   // The reset-shared bit is outside the write mask and always reads its pin.
   gpl_port #(
      .WR_MASK(`GPL_PORT3_WR_MASK),
      .RD_MASK(`GPL_PORT3_RD_MASK)
   ) u_port3 (
      .clk(clk),
      .resetn(resetn),
      .wr_en(we_p3),
      .wr_data(wr_val),
      .dir(dir3),
      .pin_lvl(lvl3),
      .latch(latch3),
      .rd_val(rd3)
   );

   gpl_port #(
      .WR_MASK(`GPL_PORT4_MASK),
      .RD_MASK(`GPL_PORT4_MASK)
   ) u_port4 (
      .clk(clk),
      .resetn(resetn),
      .wr_en(we_p4),
      .wr_data(wr_val),
      .dir(dir4),
      .pin_lvl(lvl4),
      .latch(latch4),
      .rd_val(rd4)
   );

   // Direction registers: unimplemented positions stay 1 so they act as inputs.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dir2 <= `GPL_DIR_RST;
         dir3 <= `GPL_DIR_RST;
         dir4 <= `GPL_DIR_RST;
      end else begin
         if (we_d2) begin
            dir2 <= wr_val | ~`GPL_PORT2_MASK;
         end
         if (we_d3) begin
            dir3 <= wr_val | ~`GPL_PORT3_WR_MASK;
         end
         if (we_d4) begin
            dir4 <= wr_val | ~`GPL_PORT4_MASK;
         end
      end
   end

   // Pull-up and analog-mode registers.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pullup2 <= `GPL_PULLUP_RST;
         pullup3 <= `GPL_PULLUP_RST;
         pullup4 <= `GPL_PULLUP_RST;
         analog_mode_select <= `GPL_ANALOG_RST;
      end else begin
         if (we_u2) begin
            pullup2 <= wr_val & `GPL_PORT2_MASK;
         end
         if (we_u3) begin
            pullup3 <= wr_val & `GPL_PORT3_WR_MASK;
         end
         if (we_u4) begin
            pullup4 <= wr_val & `GPL_PORT4_MASK;
         end
         if (we_am) begin
            analog_mode_select <= wr_val & `GPL_ANALOG_MASK;
         end
      end
   end

   // Read answer is registered and appears one cycle after the strobe.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cpu_rdata <= `GPL_RDATA_RST;
         cpu_rvalid <= 1'b0;
      end else begin
         cpu_rvalid <= cpu_rd;
         if (cpu_rd) begin
            cpu_rdata <= rd_mux;
         end
      end
   end

   // Pin drive. Timer outputs are ORed onto the latch, which is why software
   // must leave the latch at 0 when a timer owns the pin. Analog mode forces
   // the buffer off whatever the direction bit says.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         p2_pin_out <= 4'h0;
         p2_pin_oe <= 4'h0;
         p3_pin_out <= 1'b0;
         p3_pin_oe <= 1'b0;
         p4_pin_out <= 8'h00;
         p4_pin_oe <= 8'h00;
      end else begin
         p2_pin_out <= latch2[3:0] | {2'b00, timer0_output, timer_h_output};
         p2_pin_oe <= ~dir2[3:0] & ~analog_mode_select[3:0];
         p3_pin_out <= latch3[`GPL_P3_IO_BIT];
         p3_pin_oe <= ~dir3[`GPL_P3_IO_BIT];
         p4_pin_out <= latch4;
         p4_pin_oe <= ~dir4;
      end
   end

   // Pull-ups follow their selection bits; keeping them off on analog pins is
   // left to software so the register reads back exactly what was written.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         p2_pullup_en <= 4'h0;
         p3_pullup_en <= 1'b0;
         p4_pullup_en <= 8'h00;
         analog_mode_bit <= 4'h0;
      end else begin
         p2_pullup_en <= pullup2[3:0];
         p3_pullup_en <= pullup3[`GPL_P3_IO_BIT];
         p4_pullup_en <= pullup4;
         analog_mode_bit <= analog_mode_select[3:0];
      end
   end

   // Alternate inputs to the timers and interrupt logic are blocked in analog
   // mode so a converter voltage cannot toggle a capture or interrupt.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         timer0_capture_in_a <= 1'b0;
         timer0_capture_in_b <= 1'b0;
         ext_irq_in_0 <= 1'b0;
         ext_irq_in_1 <= 1'b0;
      end else begin
         timer0_capture_in_a <= lvl2[0];
         timer0_capture_in_b <= lvl2[1];
         ext_irq_in_0 <= lvl2[1];
         ext_irq_in_1 <= s_p32;
      end
   end
endmodule
`default_nettype wire

// [tb/gpl_asserts.sv]
// Checker for the port block, watching the top module's ports only.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module gpl_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // CPU bus
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0] cpu_wdata,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic cpu_bit_wr,
   input wire logic [7:0] cpu_rdata,
   input wire logic cpu_rvalid,
   // Pin side
   input wire logic [3:0] p2_pin_oe,
   input wire logic [3:0] p2_pullup_en,
   input wire logic [7:0] p4_pin_out,
   input wire logic [7:0] p4_pin_oe,
   input wire logic [3:0] analog_mode_bit
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // A write is judged only when no other write follows at once, so its result stands.
   wire logic quiet;
   assign quiet = ~cpu_wr & ~cpu_bit_wr;
   sequence s_wr(a);
      cpu_wr && !cpu_bit_wr && cpu_addr == a ##1 quiet;
   endsequence
   property p_rd_ans;
      cpu_rd |=> cpu_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_rd_hold;
      !cpu_rd |=> !cpu_rvalid && $stable(cpu_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_dir_oe;
      s_wr(16'hff24) |=> p4_pin_oe == ~$past(cpu_wdata, 2);
   endproperty
   a_dir_oe: assert property (p_dir_oe) else $error("oe wrong");
   property p_latch_out;
      s_wr(16'hff04) |=> p4_pin_out == $past(cpu_wdata, 2);
   endproperty
   a_latch_out: assert property (p_latch_out) else $error("latch wrong");
   property p_pull;
      s_wr(16'hff32) |=> p2_pullup_en == $past(cpu_wdata[3:0], 2);
   endproperty
   a_pull: assert property (p_pull) else $error("pull-up wrong");
   property p_ana;
      s_wr(16'hff84) |=> analog_mode_bit == $past(cpu_wdata[3:0], 2);
   endproperty
   a_ana: assert property (p_ana) else $error("analog bits wrong");
   property p_ana_oe;
      (p2_pin_oe & analog_mode_bit) == 4'h0;
   endproperty
   a_ana_oe: assert property (p_ana_oe) else $error("analog pin driven");
   property p_p3_bits;
      cpu_rd && cpu_addr == 16'hff03 |=> (cpu_rdata & 8'heb) == 8'h00;
   endproperty
   a_p3_bits: assert property (p_p3_bits) else $error("port 3 bits");
   property p_unused;
      cpu_rd && cpu_addr == 16'hff10 |=> cpu_rdata == 8'h00;
   endproperty
   a_unused: assert property (p_unused) else $error("unmapped read");
   c_rd: cover property (cpu_rvalid);
   c_ana: cover property (s_wr(16'hff84));
   c_bit: cover property (cpu_bit_wr);
endmodule
`default_nettype wire

// [tb/gpl_pins.sv]
// Model of the outside world on a group of port pins.
// Assumes the bench chooses which pins it drives from outside.
`timescale 1ns/1ps
`default_nettype none
module gpl_pins #(
   parameter W = 4
) (
   // Clock
   input wire logic clk,
   // Block side
   input wire logic [W-1:0] pin_out,
   input wire logic [W-1:0] pin_oe,
   input wire logic [W-1:0] pullup_en,
   // Outside drivers
   input wire logic [W-1:0] ext_lvl,
   input wire logic [W-1:0] ext_en,
   output logic [W-1:0] lvl
);
   logic [W-1:0] last = '0;
   wire logic [W-1:0] drv;
   assign drv = pin_oe | ext_en;
   // A floating pin without pull-up shows the inverse of its last driven level,
   // held steady, so a stale value cannot pass unnoticed.
   always_comb lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lvl)
      | (~drv & (pullup_en | ~last));
   always @(posedge clk) last <= (drv & lvl) | (~drv & last);
endmodule
`default_nettype wire

// [tb/tb.sv]
// Bench for the port block: bus tasks, pin models and a fixed test sequence.
// Assumes single-cycle strobes driven at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [15:0] cpu_addr = 16'h0000;
   logic [7:0] cpu_wdata = 8'h00;
   logic cpu_wr = 1'b0;
   logic cpu_rd = 1'b0;
   logic cpu_bit_wr = 1'b0;
   logic [2:0] cpu_bit_sel = 3'h0;
   logic cpu_bit_val = 1'b0;
   logic rsi = 1'b0;
   logic tmr_h = 1'b0;
   logic tmr0 = 1'b0;
   logic [12:0] ext_lvl = 13'h0000;
   logic [12:0] ext_en = 13'h1fff;
   logic [15:0] rst_addr [5] = '{16'hff32, 16'hff33, 16'hff34, 16'hff84, 16'hff10};
   int bad_count = 0;
   int num_checks = 0;
   wire logic [7:0] cpu_rdata;
   wire logic cpu_rvalid, p3_out, p3_oe, p3_pu, p3_lvl, cap_a, cap_b, irq0, irq1;
   wire logic [3:0] p2_out, p2_oe, p2_pu, p2_lvl, ana;
   wire logic [7:0] p4_out, p4_oe, p4_pu, p4_lvl;
   initial forever #5 clk = ~clk;
   gpl_top gpl_top_inst (.clk(clk), .resetn(resetn), .cpu_addr(cpu_addr),
      .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_bit_wr(cpu_bit_wr),
      .cpu_bit_sel(cpu_bit_sel), .cpu_bit_val(cpu_bit_val), .cpu_rdata(cpu_rdata),
      .cpu_rvalid(cpu_rvalid), .p2_pin_in(p2_lvl), .p2_pin_out(p2_out),
      .p2_pin_oe(p2_oe), .p2_pullup_en(p2_pu), .p3_pin_in(p3_lvl),
      .reset_shared_input(rsi), .p3_pin_out(p3_out), .p3_pin_oe(p3_oe),
      .p3_pullup_en(p3_pu), .p4_pin_in(p4_lvl), .p4_pin_out(p4_out), .p4_pin_oe(p4_oe),
      .p4_pullup_en(p4_pu), .analog_mode_bit(ana), .timer_h_output(tmr_h),
      .timer0_output(tmr0), .timer0_capture_in_a(cap_a), .timer0_capture_in_b(cap_b),
      .ext_irq_in_0(irq0), .ext_irq_in_1(irq1));
   gpl_pins #(.W(4)) p2_pins (.clk(clk), .pin_out(p2_out), .pin_oe(p2_oe),
      .pullup_en(p2_pu), .ext_lvl(ext_lvl[3:0]), .ext_en(ext_en[3:0]), .lvl(p2_lvl));
   gpl_pins #(.W(1)) p3_pins (.clk(clk), .pin_out(p3_out), .pin_oe(p3_oe),
      .pullup_en(p3_pu), .ext_lvl(ext_lvl[4]), .ext_en(ext_en[4]), .lvl(p3_lvl));
   gpl_pins #(.W(8)) p4_pins (.clk(clk), .pin_out(p4_out), .pin_oe(p4_oe),
      .pullup_en(p4_pu), .ext_lvl(ext_lvl[12:5]), .ext_en(ext_en[12:5]), .lvl(p4_lvl));
   task automatic give_verdict;
      if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      cpu_addr = a;
      cpu_wdata = d;
      cpu_wr = 1'b1;
      @(negedge clk);
      cpu_wr = 1'b0;
   endtask
   task automatic bw(input logic [15:0] a, input logic [2:0] s, input logic v);
      @(negedge clk);
      cpu_addr = a;
      cpu_bit_sel = s;
      cpu_bit_val = v;
      cpu_bit_wr = 1'b1;
      @(negedge clk);
      cpu_bit_wr = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
      int n = 0;
      @(negedge clk);
      cpu_addr = a;
      cpu_rd = 1'b1;
      @(negedge clk);
      cpu_rd = 1'b0;
      while (cpu_rvalid !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      if (n == 4) begin
         bad_count++;
         give_verdict();
      end else begin
         check(what, cpu_rdata, exp);
      end
   endtask
   // Pin levels take two cycles through the synchroniser, outputs one more.
   task automatic settle;
      repeat (4) @(negedge clk);
   endtask
   task automatic do_reset;
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
   endtask
   initial begin
      do_reset();
      foreach (rst_addr[i]) rd(rst_addr[i], 8'h00, "reset reg");
      check("p4 latch", p4_out, 8'h00);
      check("p4 oe", p4_oe, 8'h00);
      ext_lvl[12:5] = 8'h5a;
      wr(16'hff04, 8'ha5);
      settle();
      check("p4 latch", p4_out, 8'ha5);
      check("p4 lvl", p4_lvl, 8'h5a);
      rd(16'hff04, 8'h5a, "p4 pins");
      wr(16'hff24, 8'hf0);
      ext_en[8:5] = 4'h0;
      settle();
      check("p4 oe", p4_oe, 8'h0f);
      check("p4 lvl", p4_lvl, 8'h55);
      rd(16'hff04, 8'h55, "p4 mixed");
      rd(16'hff24, 8'hf0, "p4 dir");
      bw(16'hff04, 3'h6, 1'b0);
      settle();
      check("p4 latch", p4_out, 8'h15);
      rd(16'hff04, 8'h55, "p4 pins kept");
      ext_en[12:9] = 4'h0;
      wr(16'hff24, 8'h00);
      bw(16'hff04, 3'h0, 1'b0);
      settle();
      rd(16'hff04, 8'h14, "p4 rmw");
      check("p4 lvl", p4_lvl, 8'h14);
      wr(16'hff22, 8'h00);
      wr(16'hff02, 8'hff);
      wr(16'hff32, 8'hff);
      settle();
      check("p2 pull", {4'h0, p2_pu}, 8'h0f);
      rd(16'hff32, 8'h0f, "p2 pull reg");
      rd(16'hff22, 8'hf0, "p2 dir");
      wr(16'hff32, 8'h00);
      wr(16'hff84, 8'hf5);
      settle();
      check("p2 oe", {4'h0, p2_oe}, 8'h0a);
      rd(16'hff84, 8'h05, "analog reg");
      rd(16'hff02, 8'h0a, "p2 read");
      ext_lvl[3:0] = 4'hf;
      wr(16'hff22, 8'hff);
      settle();
      check("capture a", {7'h0, cap_a}, 8'h00);
      check("capture b", {7'h0, cap_b}, 8'h01);
      check("irq 0", {7'h0, irq0}, 8'h01);
      wr(16'hff84, 8'h02);
      settle();
      check("capture a", {7'h0, cap_a}, 8'h01);
      check("capture b", {7'h0, cap_b}, 8'h00);
      check("irq 0", {7'h0, irq0}, 8'h00);
      wr(16'hff84, 8'h00);
      wr(16'hff02, 8'h00);
      wr(16'hff22, 8'h00);
      tmr_h = 1'b1;
      settle();
      check("p2 timer h", {4'h0, p2_out}, 8'h01);
      tmr_h = 1'b0;
      tmr0 = 1'b1;
      settle();
      check("p2 timer 0", {4'h0, p2_out}, 8'h02);
      tmr0 = 1'b0;
      rsi = 1'b1;
      wr(16'hff03, 8'hff);
      settle();
      rd(16'hff03, 8'h10, "p3 input");
      ext_lvl[4] = 1'b1;
      settle();
      check("irq 1", {7'h0, irq1}, 8'h01);
      ext_lvl[4] = 1'b0;
      wr(16'hff23, 8'h00);
      settle();
      rd(16'hff03, 8'h14, "p3 output");
      check("p3 oe", {7'h0, p3_oe}, 8'h01);
      check("p3 pin", {7'h0, p3_lvl}, 8'h01);
      wr(16'hff33, 8'hff);
      wr(16'hff34, 8'h3c);
      rsi = 1'b0;
      settle();
      check("p3 pull", {7'h0, p3_pu}, 8'h01);
      check("p4 pull", p4_pu, 8'h3c);
      rd(16'hff33, 8'h04, "p3 pull reg");
      rd(16'hff03, 8'h04, "p3 reset pin");
      do_reset();
      settle();
      check("p4 latch", p4_out, 8'h00);
      check("p4 oe", p4_oe, 8'h00);
      check("analog", {4'h0, ana}, 8'h00);
      check("p4 pull", p4_pu, 8'h00);
      rd(16'hff34, 8'h00, "p4 pull reg");
      rd(16'hff24, 8'hff, "p4 dir");
      give_verdict();
   end
endmodule
bind gpl_top gpl_asserts gpl_asserts_inst (.clk(clk), .resetn(resetn),
   .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
   .cpu_bit_wr(cpu_bit_wr), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
   .p2_pin_oe(p2_pin_oe), .p2_pullup_en(p2_pullup_en), .p4_pin_out(p4_pin_out),
   .p4_pin_oe(p4_pin_oe), .analog_mode_bit(analog_mode_bit));
`default_nettype wire
